// >>> lgr_consts.svh
// register indices, field layout, reset values and timing for the logger rtc block
`ifndef LGR_CONSTS_SVH
`define LGR_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define LGR_IDX_SEC          10'h200
`define LGR_IDX_MIN          10'h201
`define LGR_IDX_HOUR         10'h202
`define LGR_IDX_WDAY         10'h203
`define LGR_IDX_DATE         10'h204
`define LGR_IDX_MONTH        10'h205
`define LGR_IDX_YEAR         10'h206
`define LGR_IDX_ASEC         10'h207
`define LGR_IDX_AMIN         10'h208
`define LGR_IDX_AHOUR        10'h209
`define LGR_IDX_AWDAY        10'h20a
`define LGR_IDX_TLOW         10'h20b
`define LGR_IDX_THIGH        10'h20c
`define LGR_IDX_RATE         10'h20d
`define LGR_IDX_CTRL         10'h20e
`define LGR_IDX_TEMP         10'h211
`define LGR_IDX_STAT         10'h214

// ----------------------------------------
// writable bit masks, fixed-zero bits read 0
// ----------------------------------------
`define LGR_MSK_SEC          8'h7f
`define LGR_MSK_MIN          8'h7f
`define LGR_MSK_HOUR         8'h7f
`define LGR_MSK_WDAY         8'h07
`define LGR_MSK_DATE         8'h3f
`define LGR_MSK_MONTH        8'h9f
`define LGR_MSK_AWDAY        8'h87
`define LGR_MSK_CTRL         8'hdf

// ----------------------------------------
// field positions
// ----------------------------------------
`define LGR_HOUR_12H         6
`define LGR_HOUR_B5          5
`define LGR_MONTH_HUNDRED_YEAR_FLAG       7
`define LGR_ALM_MASK         7
`define LGR_CTL_OSC_STOP     7
`define LGR_CTL_WIPE_ARM     6
`define LGR_CTL_MIS_EN_N     4
`define LGR_CTL_WRAP         3
`define LGR_CTL_TLS          2
`define LGR_CTL_THS          1
`define LGR_CTL_TAS          0
`define LGR_ST_WIPED         6
`define LGR_ST_MIP           5
`define LGR_ST_TLF           2
`define LGR_ST_THF           1
`define LGR_ST_TAF           0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define LGR_RST_SEC          8'h00
`define LGR_RST_WDAY         8'h01
`define LGR_RST_DATE         8'h01
`define LGR_RST_MONTH        8'h01
`define LGR_RST_CTRL         8'h00
`define LGR_CODE_UNDER       8'h00
`define LGR_CODE_OVER        8'hff
`define LGR_CODE_MINV        8'h01
`define LGR_CODE_MAXV        8'hfe

// ----------------------------------------
// timing
// ----------------------------------------
`define LGR_CLK_HZ           20000000
`define LGR_TICK_S           1
`define LGR_TICK_CYCLES      (`LGR_TICK_S * `LGR_CLK_HZ)

`endif

// >>> lgr_pkg.sv
// types shared by the logger rtc block
package lgr_pkg;
	typedef logic [7:0] lgr_byte_t;
	typedef logic [9:0] lgr_idx_t;
endpackage

// >>> lgr_rtc.sv
// logger real-time clock, time-of-day alarm, thresholds, sample rate and control byte
//
// How it works
// - hours bit 6 high selects 12-hour counting, low selects 24-hour.
// - in 12-hour counting hours bit 5 set means afternoon.
// - in 24-hour counting hours bit 5 is the twenties digit.
// - weekday counts 1 to 7 and wraps back to 1.
// - february gets a 29th when year is 00 or divisible by 4.
// - months bit 7 toggles whenever the year rolls from 99 to 00.
// - four alarm registers, top bit of each masks that field.
// - all masks clear: alarm when seconds, minutes, hours, weekday all match.
// - mask patterns give per second, minute, hour and day alarms.
// - every clock alarm sets the timer alarm status flag.
// - enabled search conditions answer a conditional search on timer alarm.
// - temperature is one unsigned byte, eighth degrees, valid codes 01-fe.
// - below range stores 00, above range stores ff.
// - out-of-range results land in histogram bins 0 and 63.
// - logged samples and forced readout share one code encoding.
// - low threshold byte then high threshold byte, same encoding.
// - sample rate gives minutes between conversions, 1 to 255.
// - non-zero rate write starts mission if memory wiped and enable low.
// - control write during a mission ends the mission, then updates.
// - control byte bits: osc stop, wipe arm, 0, enable_n, wrap, searches.
// - control bit 5 always reads 0, writing 1 is ignored.
// - time and alarm registers are bcd, fixed-zero bits read 0.
// - osc stop halts the clock; start refused until one second elapsed.
// - search answers on low, high threshold reach or timer alarm.

`include "lgr_consts.svh"

module lgr_rtc
	import lgr_pkg::*;
#(
	parameter int TICK_CYCLES = `LGR_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// temperature converter
	input  wire logic        conv_done,
	input  wire logic [7:0]  conv_code,
	input  wire logic        conv_under,
	input  wire logic        conv_over,
	// log and memory side
	input  wire logic        memory_wiped_flag,
	input  wire logic        mem_func_exec,
	input  wire logic        log_full,
	output logic             sample_valid,
	output logic [7:0]       sample_code,
	output logic [5:0]       sample_bin,
	output logic             sample_store,
	output logic             log_restart,
	// mission and search
	output logic             mission_start,
	output logic             mission_active,
	output logic             search_hit,
	output logic             second_tick
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic lgr_byte_t bcd_inc(input lgr_byte_t v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic leap_year(input lgr_byte_t y);
		logic ones4;
		logic ones2;
		ones4 = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		ones2 = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		leap_year = y[4] ? ones2 : ones4;
	endfunction

	function automatic lgr_byte_t last_day(input lgr_byte_t m, input lgr_byte_t y);
		case (m[4:0])
			5'h02:   last_day = leap_year(y) ? 8'h29 : 8'h28;
			5'h04,
			5'h06,
			5'h09,
			5'h11:   last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	function automatic lgr_byte_t hour_inc(input lgr_byte_t h);
		lgr_byte_t inc12;
		lgr_byte_t inc24;
		inc12 = bcd_inc({3'h0, h[4:0]});
		inc24 = bcd_inc({2'b00, h[5:0]});
		if (h[`LGR_HOUR_12H]) begin
			if (h[4:0] == 5'h11) begin
				hour_inc = {2'b01, ~h[`LGR_HOUR_B5], 5'h12};
			end else if (h[4:0] == 5'h12) begin
				hour_inc = {2'b01, h[`LGR_HOUR_B5], 5'h01};
			end else begin
				hour_inc = {2'b01, h[`LGR_HOUR_B5], inc12[4:0]};
			end
		end else if (h[5:0] == 6'h23) begin
			hour_inc = 8'h00;
		end else begin
			hour_inc = {2'b00, inc24[5:0]};
		end
	endfunction

	function automatic logic hour_wraps(input lgr_byte_t h);
		hour_wraps = h[`LGR_HOUR_12H] ? (h[5:0] == 6'h31) : (h[5:0] == 6'h23);
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	lgr_byte_t sec_reg, min_reg, hour_reg, wday_reg, date_reg, month_reg, year_reg;
	lgr_byte_t asec_reg, amin_reg, ahour_reg, awday_reg;
	lgr_byte_t tlow_reg, thigh_reg, rate_reg, ctrl_reg, temp_reg;
	logic      taf_reg, tlf_reg, thf_reg, mission_reg, advanced_reg;
	logic      ready_reg;
	logic [31:0] rdata_reg;
	logic [24:0] tick_cnt_reg;
	logic        tick_reg;
	logic        tick_d_reg;
	logic        alarm_hit;
	lgr_byte_t   sample_code_next;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	lgr_idx_t  idx;
	lgr_byte_t wbyte;
	logic      access;
	logic      wr;
	logic      mapped;
	logic      ctrl_wr;
	logic      rate_wr;
	lgr_byte_t rd_byte;

	assign idx    = paddr[11:2];
	assign wbyte  = pwdata[7:0];
	assign access = psel && penable && ready_reg;
	assign wr     = access && pwrite && mapped;

	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			`LGR_IDX_SEC:   rd_byte = sec_reg;
			`LGR_IDX_MIN:   rd_byte = min_reg;
			`LGR_IDX_HOUR:  rd_byte = hour_reg;
			`LGR_IDX_WDAY:  rd_byte = wday_reg;
			`LGR_IDX_DATE:  rd_byte = date_reg;
			`LGR_IDX_MONTH: rd_byte = month_reg;
			`LGR_IDX_YEAR:  rd_byte = year_reg;
			`LGR_IDX_ASEC:  rd_byte = asec_reg;
			`LGR_IDX_AMIN:  rd_byte = amin_reg;
			`LGR_IDX_AHOUR: rd_byte = ahour_reg;
			`LGR_IDX_AWDAY: rd_byte = awday_reg;
			`LGR_IDX_TLOW:  rd_byte = tlow_reg;
			`LGR_IDX_THIGH: rd_byte = thigh_reg;
			`LGR_IDX_RATE:  rd_byte = rate_reg;
			`LGR_IDX_CTRL:  rd_byte = ctrl_reg;
			`LGR_IDX_TEMP:  rd_byte = temp_reg;
			`LGR_IDX_STAT:  rd_byte = {1'b0, memory_wiped_flag, mission_reg, 2'b00,
				tlf_reg, thf_reg, taf_reg};
			default:        mapped  = 1'b0;
		endcase
	end

	assign ctrl_wr = wr && (idx == `LGR_IDX_CTRL);
	assign rate_wr = wr && (idx == `LGR_IDX_RATE);

	// one wait state: pready answers in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ready_reg <= psel && penable && !ready_reg;
			if (psel && penable && !ready_reg) begin
				rdata_reg <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign pready  = ready_reg;
	assign prdata  = rdata_reg;
	assign pslverr = ready_reg && !mapped;

	// ----------------------------------------
	// one-second tick
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 25'h000_0000;
			tick_reg     <= 1'b0;
		end else if (ctrl_reg[`LGR_CTL_OSC_STOP]) begin
			tick_cnt_reg <= 25'h000_0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 25'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 25'h000_0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 25'h000_0001;
			tick_reg     <= 1'b0;
		end
	end

	assign second_tick = tick_reg;

	// ----------------------------------------
	// timekeeping, bcd
	// ----------------------------------------
	logic sec_wrap, min_wrap, day_wrap, month_wrap, year_wrap;
	lgr_byte_t month_inc;
	assign month_inc  = bcd_inc({3'h0, month_reg[4:0]});
	assign sec_wrap   = tick_reg && (sec_reg == 8'h59);
	assign min_wrap   = sec_wrap && (min_reg == 8'h59);
	assign day_wrap   = min_wrap && hour_wraps(hour_reg);
	assign month_wrap = day_wrap && (date_reg == last_day(month_reg, year_reg));
	assign year_wrap  = month_wrap && (month_reg[4:0] == 5'h12);

	// a host write wins over a tick in the same cycle for that register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_reg   <= `LGR_RST_SEC;
			min_reg   <= `LGR_RST_SEC;
			hour_reg  <= `LGR_RST_SEC;
			wday_reg  <= `LGR_RST_WDAY;
			date_reg  <= `LGR_RST_DATE;
			month_reg <= `LGR_RST_MONTH;
			year_reg  <= `LGR_RST_SEC;
		end else begin
			if (wr && idx == `LGR_IDX_SEC) begin
				sec_reg <= wbyte & `LGR_MSK_SEC;
			end else if (tick_reg) begin
				sec_reg <= sec_wrap ? 8'h00 : bcd_inc(sec_reg);
			end
			if (wr && idx == `LGR_IDX_MIN) begin
				min_reg <= wbyte & `LGR_MSK_MIN;
			end else if (sec_wrap) begin
				min_reg <= min_wrap ? 8'h00 : bcd_inc(min_reg);
			end
			if (wr && idx == `LGR_IDX_HOUR) begin
				hour_reg <= wbyte & `LGR_MSK_HOUR;
			end else if (min_wrap) begin
				hour_reg <= hour_inc(hour_reg);
			end
			if (wr && idx == `LGR_IDX_WDAY) begin
				wday_reg <= wbyte & `LGR_MSK_WDAY;
			end else if (day_wrap) begin
				wday_reg <= (wday_reg >= 8'h07) ? 8'h01 : wday_reg + 8'h01;
			end
			if (wr && idx == `LGR_IDX_DATE) begin
				date_reg <= wbyte & `LGR_MSK_DATE;
			end else if (day_wrap) begin
				date_reg <= month_wrap ? 8'h01 : bcd_inc(date_reg);
			end
			if (wr && idx == `LGR_IDX_MONTH) begin
				month_reg <= wbyte & `LGR_MSK_MONTH;
			end else if (month_wrap) begin
				month_reg[4:0] <= year_wrap ? 5'h01 : month_inc[4:0];
				if (year_wrap && year_reg == 8'h99) begin
					month_reg[`LGR_MONTH_HUNDRED_YEAR_FLAG] <= ~month_reg[`LGR_MONTH_HUNDRED_YEAR_FLAG];
				end
			end
			if (wr && idx == `LGR_IDX_YEAR) begin
				year_reg <= wbyte;
			end else if (year_wrap) begin
				year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
			end
		end
	end

	// ----------------------------------------
	// alarm registers and match
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asec_reg  <= 8'h00;
			amin_reg  <= 8'h00;
			ahour_reg <= 8'h00;
			awday_reg <= 8'h00;
		end else if (wr) begin
			if (idx == `LGR_IDX_ASEC) begin
				asec_reg <= wbyte;
			end
			if (idx == `LGR_IDX_AMIN) begin
				amin_reg <= wbyte;
			end
			if (idx == `LGR_IDX_AHOUR) begin
				ahour_reg <= wbyte;
			end
			if (idx == `LGR_IDX_AWDAY) begin
				awday_reg <= wbyte & `LGR_MSK_AWDAY;
			end
		end
	end

	// compare one cycle after the tick so the advanced time is seen once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_d_reg <= 1'b0;
		end else begin
			tick_d_reg <= tick_reg;
		end
	end

	assign alarm_hit = tick_d_reg
		&& (asec_reg[`LGR_ALM_MASK]  || sec_reg[6:0]  == asec_reg[6:0])
		&& (amin_reg[`LGR_ALM_MASK]  || min_reg[6:0]  == amin_reg[6:0])
		&& (ahour_reg[`LGR_ALM_MASK] || hour_reg[6:0] == ahour_reg[6:0])
		&& (awday_reg[`LGR_ALM_MASK] || wday_reg[2:0] == awday_reg[2:0]);

	// ----------------------------------------
	// status flags: a set wins over a write-zero clear
	// ----------------------------------------
	logic stat_wr;
	logic temp_low, temp_high;
	assign stat_wr   = wr && (idx == `LGR_IDX_STAT);
	assign temp_low  = conv_done && mission_reg && (sample_code_next <= tlow_reg);
	assign temp_high = conv_done && mission_reg && (sample_code_next >= thigh_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taf_reg <= 1'b0;
			tlf_reg <= 1'b0;
			thf_reg <= 1'b0;
		end else begin
			taf_reg <= alarm_hit || (taf_reg && !(stat_wr && !wbyte[`LGR_ST_TAF]));
			tlf_reg <= temp_low  || (tlf_reg && !(stat_wr && !wbyte[`LGR_ST_TLF]));
			thf_reg <= temp_high || (thf_reg && !(stat_wr && !wbyte[`LGR_ST_THF]));
		end
	end

	assign search_hit = (ctrl_reg[`LGR_CTL_TAS] && taf_reg)
		|| (ctrl_reg[`LGR_CTL_TLS] && tlf_reg)
		|| (ctrl_reg[`LGR_CTL_THS] && thf_reg);

	// ----------------------------------------
	// thresholds, sample rate, control, mission
	// ----------------------------------------
	logic start_ok;
	assign start_ok = rate_wr && (wbyte != 8'h00) && memory_wiped_flag
		&& !ctrl_reg[`LGR_CTL_MIS_EN_N] && advanced_reg && !mission_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tlow_reg  <= 8'h00;
			thigh_reg <= 8'h00;
			rate_reg  <= 8'h00;
		end else if (wr) begin
			if (idx == `LGR_IDX_TLOW) begin
				tlow_reg <= wbyte;
			end
			if (idx == `LGR_IDX_THIGH) begin
				thigh_reg <= wbyte;
			end
			if (idx == `LGR_IDX_RATE) begin
				rate_reg <= wbyte;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `LGR_RST_CTRL;
		end else if (ctrl_wr) begin
			ctrl_reg <= wbyte & `LGR_MSK_CTRL;
		end else if (mem_func_exec) begin
			ctrl_reg[`LGR_CTL_WIPE_ARM] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			advanced_reg <= 1'b0;
		end else if (ctrl_reg[`LGR_CTL_OSC_STOP]) begin
			advanced_reg <= 1'b0;
		end else if (tick_reg) begin
			advanced_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mission_reg   <= 1'b0;
			mission_start <= 1'b0;
		end else begin
			mission_start <= start_ok;
			if (ctrl_wr) begin
				mission_reg <= 1'b0;
			end else if (start_ok) begin
				mission_reg <= 1'b1;
			end
		end
	end

	assign mission_active = mission_reg;

	// ----------------------------------------
	// temperature code and log steering
	// ----------------------------------------
	always_comb begin
		if (conv_under) begin
			sample_code_next = `LGR_CODE_UNDER;
		end else if (conv_over) begin
			sample_code_next = `LGR_CODE_OVER;
		end else if (conv_code < `LGR_CODE_MINV) begin
			sample_code_next = `LGR_CODE_MINV;
		end else if (conv_code > `LGR_CODE_MAXV) begin
			sample_code_next = `LGR_CODE_MAXV;
		end else begin
			sample_code_next = conv_code;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_reg     <= 8'h00;
			sample_code  <= 8'h00;
			sample_bin   <= 6'h00;
			sample_valid <= 1'b0;
			sample_store <= 1'b0;
			log_restart  <= 1'b0;
		end else begin
			sample_valid <= conv_done;
			sample_store <= conv_done && mission_reg
				&& (!log_full || ctrl_reg[`LGR_CTL_WRAP]);
			log_restart  <= conv_done && mission_reg && log_full
				&& ctrl_reg[`LGR_CTL_WRAP];
			if (conv_done) begin
				temp_reg    <= sample_code_next;
				sample_code <= sample_code_next;
				sample_bin  <= sample_code_next[7:2];
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_ctrl_bit_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[5]) else $error("control bit 5 is set");

	chk_ctrl_ends_mission: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_wr |=> !mission_reg) else $error("control write left mission running");

	chk_start_gated: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mission_reg) |-> $past(memory_wiped_flag) && $past(advanced_reg)
		&& !$past(ctrl_reg[4]) && ($past(wbyte) != 8'h00))
		else $error("mission started without its conditions");

	chk_alarm_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_hit |=> taf_reg) else $error("alarm did not set flag");

	chk_alarm_once: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_hit |-> $past(tick_reg) ##1 !alarm_hit) else $error("alarm not once per tick");

	chk_wday_wraps: assert property (@(posedge pclk) disable iff (!presetn)
		day_wrap && wday_reg == 8'h07 && !wr |=> wday_reg == 8'h01)
		else $error("weekday did not wrap to 1");

	chk_hour24_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		min_wrap && hour_reg == 8'h23 && !wr |=> hour_reg == 8'h00)
		else $error("24-hour count did not wrap");

	chk_hundred_year_flag_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		year_wrap && year_reg == 8'h99 && !wr |=> month_reg[7] != $past(month_reg[7]))
		else $error("century flag did not toggle");

	chk_code_under: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done && conv_under |=> sample_code == 8'h00 && sample_bin == 6'h00)
		else $error("under-range code wrong");

endmodule

// >>> lgr_conv_model.sv
// converter stand-in that hands the block one conversion result at a time
module lgr_conv_model (
	// clock
	input  wire logic pclk,
	// result towards the block
	output logic       conv_done,
	output logic [7:0] conv_code,
	output logic       conv_under,
	output logic       conv_over
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		conv_done = 1'b0;
		conv_code = 8'h5a;
		conv_under = 1'b0;
		conv_over = 1'b0;
	end

	// outside the strobe the code shows the inverse of the last one, so a block
	// that samples it without the strobe picks up garbage
	task automatic convert(input logic [7:0] c, input logic u, input logic o);
		conv_done <= 1'b1;
		conv_code <= c;
		conv_under <= u;
		conv_over <= o;
		@(posedge pclk);
		conv_done <= 1'b0;
		conv_code <= ~c;
		conv_under <= 1'b0;
		conv_over <= 1'b0;
	endtask
endmodule

// >>> lgr_rtc_tb_top.sv
// bench for the logger rtc block: registers, calendar, alarm, samples and mission
`include "lgr_consts.svh"
`define CHK(a, x) begin comparisons++; if ((a) !== (x)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h want %h", $time, a, x); end end

module lgr_rtc_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, pslverr, e, seen, conv_done, conv_under, conv_over;
	logic [7:0]  conv_code, sample_code;
	logic [5:0]  sample_bin;
	logic        wiped = 0, lfull = 0, s_valid, s_store, m_start, m_active, tick;
	logic        mfx = 0, hit, lrst;
	int          n_mismatch = 0, comparisons = 0, cyc = 0, n_start = 0, n_seen = 0;

	always #25 pclk = ~pclk;

	// short second so a run crosses many ticks
	lgr_rtc #(.TICK_CYCLES(40)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .conv_done(conv_done), .conv_code(conv_code),
		.conv_under(conv_under), .conv_over(conv_over), .memory_wiped_flag(wiped),
		.mem_func_exec(mfx), .log_full(lfull), .sample_valid(s_valid),
		.sample_code(sample_code), .sample_bin(sample_bin), .sample_store(s_store),
		.log_restart(lrst), .mission_start(m_start), .mission_active(m_active),
		.search_hit(hit),
		.second_tick(tick));
	lgr_conv_model CONV (.pclk(pclk), .conv_done(conv_done), .conv_code(conv_code),
		.conv_under(conv_under), .conv_over(conv_over));

	// ----------------------------------------
	// bus and helper tasks, all entered just after a rising edge
	// ----------------------------------------
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] x);
		apb(1'b0, idx, 8'h00);
		`CHK(r, {24'h0, x})
	endtask
	task automatic sync(input int extra);
		@(posedge pclk iff tick === 1'b1);
		repeat (extra) @(posedge pclk);
	endtask
	// the start pulse is gone before a write task returns, so count it where it stands
	always @(negedge pclk) begin
		if (m_start === 1'b1) begin
			n_start++;
		end
	end
	task automatic watch;
		repeat (3) @(negedge pclk);
		@(posedge pclk);
		seen = (n_start != n_seen);
		n_seen = n_start;
	endtask
	task automatic cv(input logic [7:0] c, input logic u, input logic o,
		input logic [7:0] xc, input logic [5:0] xb, input logic xs, input logic xr);
		CONV.convert(c, u, o);
		@(negedge pclk);
		`CHK({s_valid, sample_code, sample_bin, s_store, lrst}, {1'b1, xc, xb, xs, xr})
		@(posedge pclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		wiped <= 1'b1;
		wr(`LGR_IDX_CTRL, 8'hff);
		rd(`LGR_IDX_CTRL, 8'hdf);
		wr(`LGR_IDX_CTRL, 8'h00);
		rd(`LGR_IDX_CTRL, 8'h00);
		wr(`LGR_IDX_TLOW, 8'h44);
		wr(`LGR_IDX_THIGH, 8'he4);
		rd(`LGR_IDX_TLOW, 8'h44);
		rd(`LGR_IDX_THIGH, 8'he4);
		// oscillator just restarted, so this start must be refused
		wr(`LGR_IDX_RATE, 8'hff);
		watch;
		`CHK({seen, m_active}, 2'b00)
		rd(`LGR_IDX_RATE, 8'hff);
		wr(`LGR_IDX_CTRL, 8'h40);
		mfx <= 1'b1;
		@(posedge pclk);
		mfx <= 1'b0;
		rd(`LGR_IDX_CTRL, 8'h00);
		wr(`LGR_IDX_TEMP, 8'h55);
		rd(`LGR_IDX_TEMP, 8'h00);
		rd(10'h300, 8'h00);
		`CHK(e, 1'b1)
		$display("regs done");
	endtask

	task automatic t_calendar;
		sync(0);
		wr(`LGR_IDX_YEAR, 8'h04);
		wr(`LGR_IDX_MONTH, 8'h82);
		wr(`LGR_IDX_DATE, 8'h28);
		wr(`LGR_IDX_WDAY, 8'h07);
		wr(`LGR_IDX_HOUR, 8'h23);
		wr(`LGR_IDX_MIN, 8'h59);
		wr(`LGR_IDX_SEC, 8'h59);
		sync(0);
		rd(`LGR_IDX_HOUR, 8'h00);
		rd(`LGR_IDX_WDAY, 8'h01);
		rd(`LGR_IDX_DATE, 8'h29);
		sync(0);
		wr(`LGR_IDX_YEAR, 8'h99);
		wr(`LGR_IDX_MONTH, 8'h92);
		wr(`LGR_IDX_DATE, 8'h31);
		wr(`LGR_IDX_HOUR, 8'h71);
		wr(`LGR_IDX_MIN, 8'h59);
		wr(`LGR_IDX_SEC, 8'h59);
		sync(0);
		rd(`LGR_IDX_YEAR, 8'h00);
		rd(`LGR_IDX_MONTH, 8'h01);
		rd(`LGR_IDX_HOUR, 8'h52);
		$display("calendar done");
	endtask

	task automatic t_alarm;
		sync(0);
		wr(`LGR_IDX_SEC, 8'h03);
		wr(`LGR_IDX_ASEC, 8'h05);
		wr(`LGR_IDX_AMIN, 8'h80);
		wr(`LGR_IDX_AHOUR, 8'h80);
		wr(`LGR_IDX_AWDAY, 8'h80);
		wr(`LGR_IDX_STAT, 8'h00);
		sync(4);
		rd(`LGR_IDX_STAT, 8'h40);
		sync(4);
		rd(`LGR_IDX_STAT, 8'h41);
		wr(`LGR_IDX_STAT, 8'h00);
		rd(`LGR_IDX_STAT, 8'h40);
		wr(`LGR_IDX_ASEC, 8'h85);
		sync(4);
		rd(`LGR_IDX_STAT, 8'h41);
		$display("alarm done");
	endtask

	task automatic t_mission;
		cv(8'h44, 1'b0, 1'b0, 8'h44, 6'h11, 1'b0, 1'b0);
		cv(8'h10, 1'b1, 1'b0, 8'h00, 6'h00, 1'b0, 1'b0);
		cv(8'h10, 1'b0, 1'b1, 8'hff, 6'h3f, 1'b0, 1'b0);
		wr(`LGR_IDX_CTRL, 8'h18);
		wr(`LGR_IDX_RATE, 8'h01);
		watch;
		`CHK({seen, m_active}, 2'b00)
		wr(`LGR_IDX_CTRL, 8'h08);
		wr(`LGR_IDX_RATE, 8'h01);
		watch;
		`CHK({seen, m_active}, 2'b11)
		lfull <= 1'b1;
		cv(8'h50, 1'b0, 1'b0, 8'h50, 6'h14, 1'b1, 1'b1);
		wr(`LGR_IDX_CTRL, 8'h00);
		`CHK(m_active, 1'b0)
		wr(`LGR_IDX_RATE, 8'h02);
		watch;
		`CHK({seen, m_active}, 2'b11)
		cv(8'h60, 1'b0, 1'b0, 8'h60, 6'h18, 1'b0, 1'b0);
		cv(8'h30, 1'b0, 1'b0, 8'h30, 6'h0c, 1'b0, 1'b0);
		rd(`LGR_IDX_TEMP, 8'h30);
		wr(`LGR_IDX_CTRL, 8'h04);
		`CHK(hit, 1'b1)
		wr(`LGR_IDX_CTRL, 8'h01);
		`CHK(hit, 1'b1)
		wr(`LGR_IDX_CTRL, 8'h00);
		`CHK(hit, 1'b0)
		$display("mission done");
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			summarize;
		end
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_calendar;
		t_alarm;
		t_mission;
		summarize;
	end
endmodule
